// File: logic/eac_pkg.sv
package eac_pkg;

  // ----------------------------------------------------------------
  // Widths and register banks
  // ----------------------------------------------------------------
  localparam int ADDR_W = 32;
  localparam int NUM_REGS = 8;
  localparam int REG_IDX_W = 3;

  // ----------------------------------------------------------------
  // Operand sizes in bytes
  // ----------------------------------------------------------------
  localparam logic [2:0] SIZE_BYTES_B = 3'h1;
  localparam logic [2:0] SIZE_BYTES_W = 3'h2;
  localparam logic [2:0] SIZE_BYTES_L = 3'h4;

  // Address register that is the stack pointer; byte steps on it stay even.
  localparam logic [2:0] STACK_REG_IDX = 3'h7;

  // ----------------------------------------------------------------
  // Enumerations
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    EAC_MODE_DREG,
    EAC_MODE_AREG,
    EAC_MODE_IND,
    EAC_MODE_POSTINC,
    EAC_MODE_PREDEC,
    EAC_MODE_DISP,
    EAC_MODE_INDEX8,
    EAC_MODE_INDEXBD,
    EAC_MODE_MEM_POST,
    EAC_MODE_MEM_PRE,
    EAC_MODE_ABS_W,
    EAC_MODE_ABS_L,
    EAC_MODE_IMM
  } eac_mode_t;

  typedef enum logic [1:0] {
    EAC_OPSZ_BYTE,
    EAC_OPSZ_WORD,
    EAC_OPSZ_LONG
  } eac_opsz_t;

  // ----------------------------------------------------------------
  // Request and answer carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    eac_mode_t mode;
    eac_opsz_t op_size;
    logic pc_base;
    logic [2:0] base_reg;
    logic idx_is_addr;
    logic [2:0] idx_reg;
    logic idx_long;
    logic [1:0] idx_scale;
    logic idx_suppress;
    logic base_suppress;
    logic [31:0] base_displacement;
    logic bd_long;
    logic [31:0] outer_displacement;
    logic od_long;
    logic [15:0] short_disp_word;
    logic [31:0] ext_data;
  } eac_req_t;

  typedef struct packed {
    logic [31:0] addr;
    logic is_reg;
    logic is_imm;
    logic [31:0] imm;
    logic wb_en;
    logic [2:0] wb_reg;
    logic [31:0] wb_value;
  } eac_resp_t;

endpackage

// File: logic/eac_index_unit.sv
`timescale 1ns/1ps
module eac_index_unit (
  input wire logic [31:0] reg_value,
  input wire logic idx_long,
  input wire logic [1:0] idx_scale,
  input wire logic idx_suppress,
  output logic [31:0] scaled
);
  import eac_pkg::*;

  // ----------------------------------------------------------------
  // Sign extension and scaling of the index operand
  // ----------------------------------------------------------------
  wire logic [31:0] sized;
  assign sized = idx_long ? reg_value : {{16{reg_value[15]}}, reg_value[15:0]};
  assign scaled = idx_suppress ? 32'h0000_0000 : (sized << idx_scale);

endmodule

// File: logic/eac_calc.sv
`timescale 1ns/1ps
module eac_calc (
  input wire logic clock,
  input wire logic rst,
  input wire logic req_valid,
  input wire eac_pkg::eac_req_t req,
  output logic req_ready,
  input wire logic [eac_pkg::NUM_REGS*32-1:0] data_regs,
  input wire logic [eac_pkg::NUM_REGS*32-1:0] addr_regs,
  input wire logic [31:0] pc_value,
  output logic mem_rd_req,
  output logic [31:0] mem_rd_addr,
  input wire logic mem_rd_ack,
  input wire logic [31:0] mem_rd_data,
  output logic resp_valid,
  output eac_pkg::eac_resp_t resp
);
  import eac_pkg::*;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] pick_reg(input logic [NUM_REGS*32-1:0] bank,
                                           input logic [2:0] idx);
    pick_reg = bank[idx*32 +: 32];
  endfunction

  function automatic logic [31:0] sext_disp(input logic [31:0] d, input logic is_long);
    sext_disp = is_long ? d : {{16{d[15]}}, d[15:0]};
  endfunction

  function automatic logic [2:0] size_bytes(input eac_opsz_t sz, input logic [2:0] r);
    case (sz)
      EAC_OPSZ_BYTE: size_bytes = (r == STACK_REG_IDX) ? SIZE_BYTES_W : SIZE_BYTES_B;
      EAC_OPSZ_WORD: size_bytes = SIZE_BYTES_W;
      default: size_bytes = SIZE_BYTES_L;
    endcase
  endfunction

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_FETCH,
    ST_DONE
  } eac_state_t;

  // ----------------------------------------------------------------
  // Operand selection
  // ----------------------------------------------------------------
  eac_state_t state_reg, state_next;
  eac_req_t req_reg;
  logic [31:0] ptr_reg;
  logic mem_rd_req_reg;
  logic [31:0] mem_rd_addr_reg;
  logic resp_valid_reg;
  eac_resp_t resp_reg;
  logic req_ready_reg;
  logic fetch_done_reg;

  wire logic [31:0] base_areg;
  wire logic [31:0] base_val;
  wire logic [31:0] idx_src;
  wire logic [31:0] idx_scaled;
  wire logic [31:0] bd_ext;
  wire logic [31:0] od_ext;
  wire logic [31:0] d8_ext;
  wire logic [31:0] d16_ext;
  wire logic [2:0] step;
  wire logic [31:0] step32;
  wire logic [31:0] inner_addr;
  wire logic [31:0] final_post;
  wire logic [31:0] final_pre;
  logic [31:0] direct_addr;
  wire logic [31:0] imm_val;
  wire logic is_mem;
  wire logic is_pre;
  wire logic is_reg;
  wire logic start;
  wire logic need_fetch;

  assign base_areg = pick_reg(addr_regs, req_reg.base_reg);
  assign base_val = req_reg.base_suppress ? 32'h0000_0000 :
                    (req_reg.pc_base ? pc_value : base_areg);
  assign idx_src = req_reg.idx_is_addr ? pick_reg(addr_regs, req_reg.idx_reg) :
                   pick_reg(data_regs, req_reg.idx_reg);

  // ----------------------------------------------------------------
  // Index operand
  // ----------------------------------------------------------------
  eac_index_unit u_index (
    .reg_value(idx_src),
    .idx_long(req_reg.idx_long),
    .idx_scale(req_reg.idx_scale),
    .idx_suppress(req_reg.idx_suppress),
    .scaled(idx_scaled)
  );

  // ----------------------------------------------------------------
  // Displacements and step size
  // ----------------------------------------------------------------
  assign bd_ext = sext_disp(req_reg.base_displacement, req_reg.bd_long);
  assign od_ext = sext_disp(req_reg.outer_displacement, req_reg.od_long);
  assign d8_ext = {{24{req_reg.short_disp_word[7]}}, req_reg.short_disp_word[7:0]};
  assign d16_ext = {{16{req_reg.short_disp_word[15]}}, req_reg.short_disp_word};
  assign step = size_bytes(req_reg.op_size, req_reg.base_reg);
  assign step32 = {29'h0, step};

  assign is_mem = (req_reg.mode == EAC_MODE_MEM_POST) || (req_reg.mode == EAC_MODE_MEM_PRE);
  assign is_pre = (req_reg.mode == EAC_MODE_MEM_PRE);
  assign is_reg = (req_reg.mode == EAC_MODE_DREG) || (req_reg.mode == EAC_MODE_AREG);

  // ----------------------------------------------------------------
  // Address sums
  // ----------------------------------------------------------------
  assign inner_addr = base_val + bd_ext + (is_pre ? idx_scaled : 32'h0000_0000);
  assign final_post = ptr_reg + idx_scaled + od_ext;
  assign final_pre = ptr_reg + od_ext;

  // ----------------------------------------------------------------
  // Immediate operand
  // ----------------------------------------------------------------
  assign imm_val = (req_reg.op_size == EAC_OPSZ_BYTE) ? {24'h0, req_reg.ext_data[7:0]} :
                   (req_reg.op_size == EAC_OPSZ_WORD) ? {16'h0, req_reg.ext_data[15:0]} :
                   req_reg.ext_data;

  // ----------------------------------------------------------------
  // Direct mode addresses
  // ----------------------------------------------------------------
  always_comb begin
    case (req_reg.mode)
      EAC_MODE_IND: direct_addr = base_areg;
      EAC_MODE_POSTINC: direct_addr = base_areg;
      EAC_MODE_PREDEC: direct_addr = base_areg - step32;
      EAC_MODE_DISP: direct_addr = base_val + d16_ext;
      EAC_MODE_INDEX8: direct_addr = base_val + d8_ext + idx_scaled;
      EAC_MODE_INDEXBD: direct_addr = base_val + bd_ext + idx_scaled;
      EAC_MODE_ABS_W: direct_addr = {{16{req_reg.ext_data[15]}}, req_reg.ext_data[15:0]};
      EAC_MODE_ABS_L: direct_addr = req_reg.ext_data;
      default: direct_addr = 32'h0000_0000;
    endcase
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  assign start = req_valid && req_ready_reg;
  assign need_fetch = is_mem && !fetch_done_reg;

  always_comb begin
    case (state_reg)
      ST_IDLE: state_next = start ? ST_DONE : ST_IDLE;
      ST_DONE: state_next = need_fetch ? ST_FETCH : ST_IDLE;
      ST_FETCH: state_next = mem_rd_ack ? ST_DONE : ST_FETCH;
      default: state_next = ST_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // Registered datapath
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      req_reg <= '0;
      ptr_reg <= 32'h0000_0000;
      mem_rd_req_reg <= 1'b0;
      mem_rd_addr_reg <= 32'h0000_0000;
      resp_valid_reg <= 1'b0;
      resp_reg <= '0;
      req_ready_reg <= 1'b0;
      fetch_done_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      req_ready_reg <= (state_next == ST_IDLE);
      resp_valid_reg <= 1'b0;
      if (start) begin
        req_reg <= req;
        fetch_done_reg <= 1'b0;
      end
      if (state_reg == ST_DONE && need_fetch) begin
        mem_rd_req_reg <= 1'b1;
        mem_rd_addr_reg <= inner_addr;
      end else if (state_reg == ST_FETCH && mem_rd_ack) begin
        ptr_reg <= mem_rd_data;
        mem_rd_req_reg <= 1'b0;
        fetch_done_reg <= 1'b1;
      end
      if (state_reg == ST_DONE && !need_fetch) begin
        resp_valid_reg <= 1'b1;
        fetch_done_reg <= 1'b0;
        resp_reg.addr <= is_mem ? (is_pre ? final_pre : final_post) : direct_addr;
        resp_reg.is_reg <= is_reg;
        resp_reg.is_imm <= (req_reg.mode == EAC_MODE_IMM);
        resp_reg.imm <= imm_val;
        resp_reg.wb_en <= (req_reg.mode == EAC_MODE_POSTINC) ||
                          (req_reg.mode == EAC_MODE_PREDEC);
        resp_reg.wb_reg <= req_reg.base_reg;
        resp_reg.wb_value <= (req_reg.mode == EAC_MODE_POSTINC) ?
                             base_areg + step32 : base_areg - step32;
      end
    end
  end

  // ----------------------------------------------------------------
  // Output drive
  // ----------------------------------------------------------------
  assign req_ready = req_ready_reg;
  assign mem_rd_req = mem_rd_req_reg;
  assign mem_rd_addr = mem_rd_addr_reg;
  assign resp_valid = resp_valid_reg;
  assign resp = resp_reg;

endmodule

// File: test/eac_calc_chk.sv
`timescale 1ns/1ps
module eac_calc_chk (
  input wire logic clock,
  input wire logic rst,
  input wire logic req_valid,
  input wire eac_pkg::eac_req_t req,
  input wire logic req_ready,
  input wire logic [eac_pkg::NUM_REGS*32-1:0] data_regs,
  input wire logic [eac_pkg::NUM_REGS*32-1:0] addr_regs,
  input wire logic [31:0] pc_value,
  input wire logic mem_rd_req,
  input wire logic [31:0] mem_rd_addr,
  input wire logic mem_rd_ack,
  input wire logic [31:0] mem_rd_data,
  input wire logic resp_valid,
  input wire eac_pkg::eac_resp_t resp
);
  import eac_pkg::*;
  // ------
  // Captured request and port relations.
  // ------
  eac_req_t cap_reg;
  wire take = req_valid && req_ready;
  wire ind = req.mode inside {EAC_MODE_MEM_POST, EAC_MODE_MEM_PRE};
  wire [31:0] base = addr_regs[cap_reg.base_reg*32+:32];
  wire [31:0] sdw = 32'($signed(cap_reg.short_disp_word));
  wire lw = resp_valid && cap_reg.op_size == EAC_OPSZ_LONG;
  always_ff @(posedge clock) begin
    if (rst) begin
      cap_reg <= '0;
    end else if (take) begin
      cap_reg <= req;
    end
  end
  default clocking @(posedge clock);
  endclocking
  default disable iff (rst);
  a_take_answer: assert property (take && !ind |-> ##2 resp_valid)
    else $error("late answer");
  a_fetch_start: assert property (take && ind |-> ##2 mem_rd_req)
    else $error("no pointer fetch");
  a_fetch_hold: assert property (mem_rd_req && !mem_rd_ack |=> mem_rd_req && $stable(mem_rd_addr))
    else $error("fetch dropped");
  a_outer_late: assert property (mem_rd_req && mem_rd_ack |-> ##2 resp_valid)
    else $error("late indirect answer");
  a_no_fetch: assert property (take && !ind |=> !mem_rd_req [*2])
    else $error("stray fetch");
  a_disp_sum: assert property (resp_valid && cap_reg.mode == EAC_MODE_DISP
    && !cap_reg.pc_base |-> resp.addr == base + sdw)
    else $error("bad displacement sum");
  a_postinc_step: assert property (lw && cap_reg.mode == EAC_MODE_POSTINC
    |-> resp.addr == base && resp.wb_value == base + 32'h4)
    else $error("bad postincrement");
  a_predec_step: assert property (lw && cap_reg.mode == EAC_MODE_PREDEC
    |-> resp.addr == base - 32'h4 && resp.wb_value == resp.addr)
    else $error("bad predecrement");
  a_imm_byte: assert property (resp_valid && cap_reg.mode == EAC_MODE_IMM
    && cap_reg.op_size == EAC_OPSZ_BYTE |-> resp.imm == {24'h0, cap_reg.ext_data[7:0]})
    else $error("bad byte immediate");
  a_reg_direct: assert property (resp_valid && cap_reg.mode == EAC_MODE_DREG |-> resp.is_reg)
    else $error("register direct flag");
endmodule
bind eac_calc eac_calc_chk u_chk (.clock, .rst, .req_valid, .req, .req_ready, .data_regs,
  .addr_regs, .pc_value, .mem_rd_req, .mem_rd_addr, .mem_rd_ack, .mem_rd_data, .resp_valid,
  .resp);

// File: test/effective_address_calc_tb_top.sv
`timescale 1ns/1ps
module effective_address_calc_tb_top;
  import eac_pkg::*;
  // ------
  // Stimulus, model and comparison.
  // ------
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic req_valid = 1'b0;
  logic mem_rd_ack = 1'b0;
  logic [31:0] mem_rd_data = 32'h0;
  logic [31:0] pc_value = 32'h0;
  logic [NUM_REGS*32-1:0] data_regs = '0;
  logic [NUM_REGS*32-1:0] addr_regs = '0;
  eac_req_t req = '0;
  eac_req_t r;
  logic req_ready, mem_rd_req, resp_valid;
  logic [31:0] mem_rd_addr;
  eac_resp_t resp;
  int error_cnt = 0;
  int n_tests = 0;
  eac_calc dut (.clock, .rst, .req_valid, .req, .req_ready, .data_regs, .addr_regs, .pc_value,
    .mem_rd_req, .mem_rd_addr, .mem_rd_ack, .mem_rd_data, .resp_valid, .resp);
  initial begin
    forever #12.5 clock = ~clock;
  end
  task automatic test_done;
    if (error_cnt == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic run;
    logic [31:0] b, x, bd, od, in, a, st, p;
    int k;
    b = r.pc_base ? pc_value : addr_regs[r.base_reg*32+:32];
    x = r.idx_is_addr ? addr_regs[r.idx_reg*32+:32] : data_regs[r.idx_reg*32+:32];
    x = (r.idx_long ? x : 32'($signed(x[15:0]))) << r.idx_scale;
    if (r.base_suppress) b = 32'h0;
    if (r.idx_suppress) x = 32'h0;
    bd = r.bd_long ? r.base_displacement : 32'($signed(r.base_displacement[15:0]));
    od = r.od_long ? r.outer_displacement : 32'($signed(r.outer_displacement[15:0]));
    in = b + bd + (r.mode == EAC_MODE_MEM_PRE ? x : 32'h0);
    st = r.op_size == EAC_OPSZ_LONG ? 32'h4 :
      (r.op_size == EAC_OPSZ_WORD || r.base_reg == STACK_REG_IDX) ? 32'h2 : 32'h1;
    p = $urandom;
    case (r.mode)
      EAC_MODE_PREDEC: a = b - st;
      EAC_MODE_DISP: a = b + 32'($signed(r.short_disp_word));
      EAC_MODE_INDEX8: a = b + x + 32'($signed(r.short_disp_word[7:0]));
      EAC_MODE_INDEXBD: a = b + bd + x;
      EAC_MODE_ABS_W: a = 32'($signed(r.ext_data[15:0]));
      EAC_MODE_ABS_L: a = r.ext_data;
      EAC_MODE_MEM_PRE: a = p + od;
      EAC_MODE_MEM_POST: a = p + x + od;
      EAC_MODE_IMM: a = r.ext_data & (r.op_size == EAC_OPSZ_LONG ? 32'hffffffff :
        r.op_size == EAC_OPSZ_WORD ? 32'hffff : 32'hff);
      default: a = r.mode inside {EAC_MODE_DREG, EAC_MODE_AREG} ? 32'h0 : b;
    endcase
    chk({31'h0, req_ready}, 32'h1);
    req = r;
    req_valid = 1'b1;
    for (k = 0; k < 9 && !req_ready; k++) @(posedge clock) #1;
    @(posedge clock) #1;
    req_valid = 1'b0;
    for (k = 0; k < 40 && !resp_valid; k++) begin
      if (mem_rd_req) begin
        chk(mem_rd_addr, in);
        repeat ($urandom_range(3)) @(posedge clock) #1;
        mem_rd_ack = 1'b1;
        mem_rd_data = p;
        @(posedge clock) #1;
        mem_rd_ack = 1'b0;
        mem_rd_data = ~p;
      end else begin
        @(posedge clock) #1;
      end
    end
    chk({31'h0, resp_valid}, 32'h1);
    chk(r.mode == EAC_MODE_IMM ? resp.imm : resp.addr, a);
    chk({31'h0, resp.is_reg}, {31'h0, r.mode inside {EAC_MODE_DREG, EAC_MODE_AREG}});
    chk({31'h0, resp.is_imm}, {31'h0, r.mode == EAC_MODE_IMM});
    if (r.mode inside {EAC_MODE_POSTINC, EAC_MODE_PREDEC}) begin
      chk(resp.wb_value, r.mode == EAC_MODE_PREDEC ? a : b + st);
      chk({28'h0, resp.wb_en, resp.wb_reg}, {28'h0, 1'b1, r.base_reg});
    end else begin
      chk({31'h0, resp.wb_en}, 32'h0);
    end
  endtask
  initial begin
    logic [159:0] rnd;
    int m;
    void'($urandom(18));
    repeat (2) @(posedge clock) #1;
    rst = 1'b0;
    for (int i = 0; i < 132; i++) begin
      m = i % 13;
      rnd = {$urandom, $urandom, $urandom, $urandom, $urandom};
      r = rnd[$bits(eac_req_t)-1:0];
      r.mode = eac_mode_t'(4'(m));
      r.op_size = eac_opsz_t'(2'($urandom_range(2)));
      r.pc_base = r.pc_base && m > 4 && m < 10;
      r.idx_suppress = r.idx_suppress && m > 6 && m < 10;
      r.base_suppress = r.base_suppress && m > 6 && m < 10;
      if (i % 2 == 0) begin
        @(posedge clock) #1;
        for (int j = 0; j < 256; j += 32) begin
          data_regs[j+:32] = $urandom;
          addr_regs[j+:32] = $urandom;
        end
        pc_value = $urandom;
      end
      run;
    end
    test_done;
  end
  initial begin
    #200000;
    error_cnt++;
    test_done;
  end
endmodule
